// [logic/acc_logic_compare_incdec_alu.sv]
// alu slice: indexed compare, inc/dec, and/or/xor with flags, behind ahb-lite
//
// The implementer's own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/10ps
module acc_logic_compare_incdec_alu #(
  parameter int MEM_AW = 4, // operand memory address bits
  parameter int STATE_DIV = alu_pkg::STATE_CYC // clock cycles per processor state
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic busy
);
  import alu_pkg::*;

  // bus data-phase capture; the address phase is latched here and the
  // data phase is acted on one cycle later, as the bus requires
  logic dp_wr; // write pending in data phase
  logic dp_rd; // read pending in data phase
  logic [7:0] dp_addr; // latched byte address

  // architectural state
  // all of it is software visible through the register window
  logic [7:0] acc; // accumulator
  logic [7:0] flags; // condition flags
  logic [15:0] idx_first; // first index register
  logic [15:0] idx_second; // second index register
  logic [7:0] regs [6]; // general registers, codes 0..5
  logic [7:0] mem [1 << MEM_AW]; // operand memory
  logic [7:0] stat_states; // states of last accepted command
  logic [7:0] stat_mcyc; // machine cycles of last accepted command
  logic illegal; // last command was not executable

  // latched command
  // held for the whole run so bus traffic cannot disturb an operation
  run_t run;
  kind_t k_kind;
  logic [2:0] k_sel; // register code of operand/destination
  logic k_mem; // operand lives in memory
  logic k_imm_use; // operand is the immediate byte
  logic [7:0] k_imm;
  logic [MEM_AW-1:0] k_addr; // memory word index
  logic [4:0] k_states;

  // state divider and counter
  // a processor state lasts STATE_DIV clock cycles; tick marks its end
  logic [$clog2(STATE_DIV+1)-1:0] div;
  logic tick; // one-cycle pulse per processor state
  logic [4:0] st_cnt;
  logic last_state;

  // write strobes
  // commit is the single cycle in which results land
  logic wr_ok;
  logic commit;

  // zero-wait slave: never stalls, always okay
  // the trade: no stall logic, but writes during a run are dropped
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign busy = (run == S_RUN);

  // address phase capture; only whole-word transfers are expected
  // hsize is not checked, so narrow transfers act as whole words
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr <= 1'b0;
      dp_rd <= 1'b0;
      dp_addr <= 8'h00;
    end else if (hready) begin
      // only a selected, active transfer opens a data phase
      dp_wr <= hsel & htrans[1] & hwrite;
      dp_rd <= hsel & htrans[1] & ~hwrite;
      dp_addr <= {haddr[7:2], 2'b00};
    end
  end

  // registers are frozen while a command runs so operands stay stable
  // a dropped write still answers okay, software must poll busy first
  assign wr_ok = dp_wr & ~busy;

  // command decode straight from the written word
  // byte 0 is either the opcode or an index prefix; after a prefix the
  // opcode and the displacement follow in bytes 1 and 2
  // decoding is purely combinational off hwdata during the data phase
  logic [7:0] b0, opc, arg;
  logic pre;
  logic [15:0] ibase, iaddr, ptr;
  logic d_ok, d_mem, d_imm;
  kind_t d_kind;
  logic [2:0] d_sel;
  logic [4:0] d_st;
  logic [2:0] d_mc;
  logic [15:0] d_addr;

  always_comb begin
    b0 = hwdata[7:0];
    pre = (b0 == PFX_FIRST) || (b0 == PFX_SECOND);
    opc = pre ? hwdata[15:8] : b0;
    arg = pre ? hwdata[23:16] : hwdata[15:8];
    ibase = (b0 == PFX_SECOND) ? idx_second : idx_first;
    iaddr = ibase + {{8{arg[7]}}, arg};
    ptr = {regs[4], regs[5]};
    d_addr = pre ? iaddr : ptr;
    // defaults first: anything unmatched stays refused
    d_ok = 1'b0;
    d_mem = 1'b0;
    d_imm = 1'b0;
    d_kind = K_AND;
    d_sel = opc[2:0];
    d_st = ST_REG;
    d_mc = MC_REG;
    if (opc[7:6] == 2'b00 && opc[2:1] == 2'b10) begin
      // increment / decrement family
      d_kind = opc[0] ? K_DEC : K_INC;
      d_sel = opc[5:3];
      d_mem = (opc[5:3] == CODE_MEM);
      // a prefix is only legal with the memory operand
      d_ok = pre ? d_mem : 1'b1;
      if (d_mem && pre) begin
        d_st = ST_IDX_RMW;
        d_mc = MC_IDX_RMW;
      end else if (d_mem) begin
        d_st = opc[0] ? ST_DEC_PTR : ST_INC_PTR;
        d_mc = MC_PTR_RMW;
      end
    end else if (opc[7:6] == 2'b10) begin
      // logic/compare family, operand code in bits 2..0
      d_mem = (opc[2:0] == CODE_MEM);
      case (opc[5:3])
        3'h4: d_kind = K_AND;
        3'h5: d_kind = K_XOR;
        3'h6: d_kind = K_OR;
        3'h7: d_kind = K_CMP;
        // the arithmetic rows are outside this slice
        default: d_kind = K_INC;
      endcase
      // compare only indexed, xor only register in this slice
      d_ok = opc[5] && (pre ? d_mem : 1'b1)
             && !(d_kind == K_CMP && !pre) && !(d_kind == K_XOR && d_mem);
      if (d_mem && pre) begin
        d_st = ST_IDX_RD;
        d_mc = MC_IDX_RD;
      end else if (d_mem) begin
        d_st = ST_MEM;
        d_mc = MC_MEM;
      end
    end else if (!pre && (opc == OPC_AND_IMM || opc == OPC_OR_IMM)) begin
      // immediate forms: operand is byte 1 of the command word
      d_kind = (opc == OPC_AND_IMM) ? K_AND : K_OR;
      d_imm = 1'b1;
      d_ok = 1'b1;
      d_st = ST_MEM;
      d_mc = MC_MEM;
    end
  end

  // command latch and status
  // a refused command only raises illegal; the last good status stays
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      k_kind <= K_AND;
      k_sel <= 3'h0;
      k_mem <= 1'b0;
      k_imm_use <= 1'b0;
      k_imm <= 8'h00;
      k_addr <= '0;
      k_states <= ST_REG;
      stat_states <= 8'h00;
      stat_mcyc <= 8'h00;
      illegal <= 1'b0;
    end else if (wr_ok && dp_addr == OFS_CMD) begin
      illegal <= ~d_ok;
      if (d_ok) begin
        k_kind <= d_kind;
        k_sel <= d_sel;
        k_mem <= d_mem;
        k_imm_use <= d_imm;
        k_imm <= arg;
        k_addr <= d_addr[MEM_AW-1:0];
        k_states <= d_st;
        stat_states <= {3'h0, d_st};
        stat_mcyc <= {5'h0, d_mc};
      end
    end
  end

  // sequencer: runs the command for its documented state count
  assign tick = (div == STATE_DIV - 1);
  assign last_state = tick && (st_cnt == k_states - 5'h01);
  assign commit = busy && last_state;

  // a command can only start from idle, so a write during a run is lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run <= S_IDLE;
    end else begin
      case (run)
        S_IDLE: if (wr_ok && dp_addr == OFS_CMD && d_ok) run <= S_RUN;
        S_RUN: if (last_state) run <= S_IDLE;
        default: run <= S_IDLE;
      endcase
    end
  end

  // state divider and state counter, restarted per command
  // holding both at zero while idle makes every command start on a
  // clean state boundary
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div <= '0;
      st_cnt <= 5'h00;
    end else if (!busy) begin
      div <= '0;
      st_cnt <= 5'h00;
    end else if (tick) begin
      div <= '0;
      st_cnt <= st_cnt + 5'h01;
    end else begin
      div <= div + 1'b1;
    end
  end

  // operand fetch and result/flag computation
  // one shared unit; the kind latched with the command picks the result
  logic [7:0] opnd, res;
  logic [8:0] diff;
  logic [7:0] nflags;

  always_comb begin
    if (k_imm_use) opnd = k_imm;
    else if (k_mem) opnd = mem[k_addr];
    else if (k_sel == CODE_ACC) opnd = acc;
    else opnd = regs[k_sel];
    diff = {1'b0, acc} - {1'b0, opnd};
    nflags = flags;
    res = acc;
    case (k_kind)
      K_INC: begin
        // half-carry out of bit 3, overflow only from 7F
        res = opnd + 8'h01;
        nflags[FLAG_H] = (opnd[3:0] == 4'hF);
        nflags[FLAG_PV] = (opnd == 8'h7F);
        nflags[FLAG_N] = 1'b0;
      end
      K_DEC: begin
        // borrow into bit 3, overflow only from 80
        res = opnd - 8'h01;
        nflags[FLAG_H] = (opnd[3:0] == 4'h0);
        nflags[FLAG_PV] = (opnd == 8'h80);
        nflags[FLAG_N] = 1'b1;
      end
      K_CMP: begin
        // all flags follow the subtraction; the difference is discarded
        res = diff[7:0];
        nflags[FLAG_C] = diff[8];
        nflags[FLAG_H] = (acc[3:0] < opnd[3:0]);
        nflags[FLAG_PV] = (acc[7] ^ opnd[7]) & (acc[7] ^ diff[7]);
        nflags[FLAG_N] = 1'b1;
      end
      default: begin
        // and, or, xor share one flag recipe
        if (k_kind == K_AND) res = acc & opnd;
        else if (k_kind == K_OR) res = acc | opnd;
        else res = acc ^ opnd;
        nflags[FLAG_C] = 1'b0;
        nflags[FLAG_H] = (k_kind == K_AND);
        nflags[FLAG_PV] = ~^res;
        nflags[FLAG_N] = 1'b0;
      end
    endcase
    nflags[FLAG_S] = res[7];
    nflags[FLAG_Z] = (res == 8'h00);
  end

  // flag register: bus write when idle, alu update at commit
  // the two sources never meet: bus writes need idle, commit needs a run
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) flags <= FLAGS_RST;
    else if (commit) flags <= nflags;
    else if (wr_ok && dp_addr == OFS_FLAGS) flags <= hwdata[7:0];
  end

  // accumulator: compare never writes it
  // inc/dec only write it when the destination code is seven
  logic acc_dst;
  assign acc_dst = (k_kind == K_AND) || (k_kind == K_OR) || (k_kind == K_XOR)
                   || ((k_kind == K_INC || k_kind == K_DEC) && !k_mem && k_sel == CODE_ACC);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) acc <= ACC_RST;
    else if (commit && acc_dst) acc <= res;
    else if (wr_ok && dp_addr == OFS_ACC) acc <= hwdata[7:0];
  end

  // index registers
  // both are written by one word; there is no way to write only one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idx_first <= IDX_RST;
      idx_second <= IDX_RST;
    end else if (wr_ok && dp_addr == OFS_IDX) begin
      idx_first <= hwdata[15:0];
      idx_second <= hwdata[31:16];
    end
  end

  // general registers, one per generate entry
  // codes 4 and 5 form the pointer pair used for memory operands
  for (genvar g = 0; g < 6; g++) begin : g_reg
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) regs[g] <= 8'h00;
      else if (commit && !k_mem && !acc_dst && (k_kind == K_INC || k_kind == K_DEC)
               && k_sel == 3'(g)) regs[g] <= res;
      else if (wr_ok && dp_addr == OFS_REGS + 8'(4 * g)) regs[g] <= hwdata[7:0];
    end
  end

  // operand memory, read-modify-write target for memory inc/dec
  // only the low MEM_AW bits of an effective address select a byte
  for (genvar m = 0; m < (1 << MEM_AW); m++) begin : g_mem
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) mem[m] <= 8'h00;
      else if (commit && k_mem && (k_kind == K_INC || k_kind == K_DEC)
               && k_addr == MEM_AW'(m)) mem[m] <= res;
      else if (wr_ok && dp_addr == OFS_MEM + 8'(4 * m)) mem[m] <= hwdata[7:0];
    end
  end

  // read mux in the data phase; unmapped offsets read zero
  // combinational so a read right after a write sees the new value
  always_comb begin
    hrdata = 32'h0000_0000;
    if (dp_rd) begin
      if (dp_addr == OFS_ACC) hrdata = {24'h0, acc};
      else if (dp_addr == OFS_FLAGS) hrdata = {24'h0, flags};
      else if (dp_addr == OFS_IDX) hrdata = {idx_second, idx_first};
      else if (dp_addr == OFS_STATUS) hrdata = {8'h0, stat_mcyc, stat_states, 6'h0, illegal, busy};
      // codes 6 and 7 have no slot here: memory and acc are mapped apart
      else if (dp_addr >= OFS_REGS && dp_addr < OFS_REGS + 8'h18)
        hrdata = {24'h0, regs[3'(dp_addr[4:2])]};
      else if (dp_addr >= OFS_MEM && dp_addr < OFS_MEM + 8'(4 << MEM_AW))
        hrdata = {24'h0, mem[dp_addr[MEM_AW+1:2]]};
    end
  end
endmodule

// [logic/alu_pkg.sv]
// constants, offsets and types for the logic/compare/inc-dec alu slice
package alu_pkg;
  // register byte offsets on the ahb-lite port
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_ACC = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_IDX = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_REGS = 8'h20;
  localparam logic [7:0] OFS_MEM = 8'h40;
  // flag bit positions in the flag register
  localparam int FLAG_S = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_H = 4;
  localparam int FLAG_PV = 2;
  localparam int FLAG_N = 1;
  localparam int FLAG_C = 0;
  // reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [15:0] IDX_RST = 16'h0000;
  // opcode bytes
  localparam logic [7:0] PFX_FIRST = 8'hDD;
  localparam logic [7:0] PFX_SECOND = 8'hFD;
  localparam logic [7:0] OPC_AND_IMM = 8'hE6;
  localparam logic [7:0] OPC_OR_IMM = 8'hF6;
  localparam logic [2:0] CODE_MEM = 3'h6;
  localparam logic [2:0] CODE_ACC = 3'h7;
  // state (t) counts and machine cycle counts per form
  localparam logic [4:0] ST_REG = 5'h04;
  localparam logic [4:0] ST_MEM = 5'h07;
  localparam logic [4:0] ST_INC_PTR = 5'h0A;
  localparam logic [4:0] ST_DEC_PTR = 5'h0B;
  localparam logic [4:0] ST_IDX_RD = 5'h13;
  localparam logic [4:0] ST_IDX_RMW = 5'h17;
  localparam logic [2:0] MC_REG = 3'h1;
  localparam logic [2:0] MC_MEM = 3'h2;
  localparam logic [2:0] MC_PTR_RMW = 3'h3;
  localparam logic [2:0] MC_IDX_RD = 3'h5;
  localparam logic [2:0] MC_IDX_RMW = 3'h6;
  // processor state period and the clock cycles it spans
  localparam int CLK_NS = 5;
  localparam int STATE_NS = 250;
  localparam int STATE_CYC = STATE_NS / CLK_NS;
  // operation kinds
  typedef enum logic [2:0] {
    K_INC = 3'h0, K_DEC = 3'h1, K_AND = 3'h2, K_OR = 3'h3, K_XOR = 3'h4, K_CMP = 3'h5
  } kind_t;
  // sequencer states, one-hot
  typedef enum logic [1:0] {
    S_IDLE = 2'b01,
    S_RUN = 2'b10
  } run_t;
endpackage

// [sim/acc_logic_compare_incdec_alu_properties.sv]
// port-level checks on the alu slice, bound into its top module
`timescale 1ns/10ps
module alu_checker
  import alu_pkg::*;
#(
  parameter int STATE_DIV = 2 // clock cycles per processor state
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic busy
);
  logic tk; // address phase taken this edge
  logic wr_cmd; // command write taken
  logic rd_dp; // read data phase now
  logic [7:0] rd_a; // address of that read
  logic st_rd; // status read data phase
  int cnt; // busy cycles so far
  assign tk = hsel & htrans[1] & hready;
  assign wr_cmd = tk & hwrite & (haddr[7:2] == 6'h00);
  assign st_rd = rd_dp & (rd_a == OFS_STATUS);
  // follow the data phase of each read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_dp <= 1'b0;
      rd_a <= 8'h00;
    end else begin
      rd_dp <= tk & ~hwrite;
      rd_a <= haddr[7:0];
    end
  end
  // length of the busy stretch, cleared while idle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      cnt <= 0;
    else
      cnt <= busy ? cnt + 1 : 0;
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_busy_cause: assert property (
    $rose(busy) |-> $past(wr_cmd, 2)) else $error("busy rose without a command write");
  a_busy_hold: assert property (
    $rose(busy) |-> busy[*4]) else $error("busy shorter than four cycles");
  a_busy_length: assert property (
    $fell(busy) |-> (cnt % STATE_DIV == 0) && (cnt / STATE_DIV) inside {4, 7, 10, 11, 19, 23})
    else $error("busy length not a legal state count");
  a_reg_cycles: assert property (
    st_rd && hrdata[12:8] == ST_REG |-> hrdata[18:16] == MC_REG) else $error("reg cycles");
  a_mem_cycles: assert property (
    st_rd && hrdata[12:8] == ST_MEM |-> hrdata[18:16] == MC_MEM) else $error("mem cycles");
  a_ptr_cycles: assert property (
    st_rd && (hrdata[12:8] == ST_INC_PTR || hrdata[12:8] == ST_DEC_PTR)
    |-> hrdata[18:16] == MC_PTR_RMW) else $error("pointer rmw cycles");
  a_idx_read: assert property (
    st_rd && hrdata[12:8] == ST_IDX_RD |-> hrdata[18:16] == MC_IDX_RD) else $error("idx cycles");
  a_idx_rmw: assert property (
    st_rd && hrdata[12:8] == ST_IDX_RMW |-> hrdata[18:16] == MC_IDX_RMW) else $error("rmw cycles");
endmodule
bind acc_logic_compare_incdec_alu alu_checker #(.STATE_DIV(STATE_DIV)) u_chk (.hclk, .hresetn,
  .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .busy);

// [sim/acc_logic_compare_incdec_alu_tb.sv]
// self-checking bench: commands over ahb-lite against a shadow model
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); end end
module acc_logic_compare_incdec_alu_tb;
  import alu_pkg::*;
  localparam int SD = 2; // short state so runs stay brief
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, busy;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int n_errors = 0;
  int compares = 0;
  int tno = 0;
  logic [7:0] sh [8]; // shadow registers, code 7 is acc
  logic [7:0] mm [16]; // shadow operand memory
  logic [7:0] fl; // shadow flags
  acc_logic_compare_incdec_alu #(.MEM_AW(4), .STATE_DIV(SD)) uut (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .busy);
  // free running bus clock
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // wait for ready at a rising edge and take read data at that edge
  task automatic ready_edge;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      rd = hrdata;
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    `CHK({hreadyout, hresp}, 2'b10)
  endtask
  // one single word transfer, entered just after a rising edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'b10;
    ready_edge();
    htrans <= 2'b00;
    hwdata <= wd;
    ready_edge();
  endtask
  // read and compare under a mask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h00000000);
    `CHK(rd & m, e)
  endtask
  // issue one command, time it, and compare against the shadow model
  task automatic run(input logic [31:0] c, input kind_t k, input int src, input int loc,
      input int st, input int mc);
    int n;
    logic [7:0] a, b, r, ad;
    logic c0;
    a = sh[7];
    b = (src == 2) ? c[15:8] : (src == 1) ? mm[loc] : sh[loc];
    c0 = fl[FLAG_C];
    xfer(1'b1, OFS_CMD, c);
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (busy === 1'b1 && n < 200);
    @(posedge hclk);
    `CHK(n - 1, st * SD)
    case (k)
      K_INC: r = b + 8'h01;
      K_DEC: r = b - 8'h01;
      K_AND: r = a & b;
      K_OR: r = a | b;
      K_XOR: r = a ^ b;
      default: r = a - b;
    endcase
    fl = {r[7], r == 8'h00, 4'h0, 1'b0, 1'b0};
    fl[FLAG_PV] = ~^r;
    fl[FLAG_H] = (k == K_AND);
    if (k == K_INC || k == K_DEC) begin
      fl[FLAG_C] = c0;
      fl[FLAG_H] = (k == K_INC) ? (b[3:0] == 4'hF) : (b[3:0] == 4'h0);
      fl[FLAG_PV] = (k == K_INC) ? (b == 8'h7F) : (b == 8'h80);
      if (src == 1)
        mm[loc] = r;
      else
        sh[loc] = r;
    end else if (k == K_CMP) begin
      fl[FLAG_H] = a[3:0] < b[3:0];
      fl[FLAG_PV] = (a[7] ^ b[7]) & (a[7] ^ r[7]);
      fl[FLAG_C] = a < b;
    end else
      sh[7] = r;
    fl[FLAG_N] = (k == K_DEC || k == K_CMP);
    rchk(OFS_ACC, 32'hFF, {24'h000000, sh[7]});
    rchk(OFS_FLAGS, 32'hD7, {24'h000000, fl});
    ad = (src == 1 ? OFS_MEM : OFS_REGS) + 8'(loc * 4);
    if (k == K_INC || k == K_DEC)
      rchk(ad, 32'hFF, {24'h000000, src == 1 ? mm[loc] : sh[loc]});
    rchk(OFS_STATUS, 32'hFFFF00, {8'h00, 8'(mc), 8'(st), 8'h00});
    tno++;
    $display("test %0d done", tno);
  endtask
  // print counts and verdict, then stop
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard, far beyond the expected run length
  initial begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    conclude();
  end
  // main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h00000000;
    sh = '{8'h80, 8'h0F, 8'h7F, 8'h55, 8'h12, 8'h3F, 8'h00, 8'h3C};
    fl = 8'h01;
    for (int i = 0; i < 16; i++)
      mm[i] = 8'(i * 17);
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(OFS_ACC, 32'hFFFFFFFF, 32'h00000000);
    rchk(OFS_FLAGS, 32'hFFFFFFFF, 32'h00000000);
    rchk(OFS_IDX, 32'hFFFFFFFF, 32'h00000000);
    $display("reset test done");
    for (int i = 0; i < 6; i++)
      xfer(1'b1, OFS_REGS + 8'(i * 4), {24'h000000, sh[i]});
    for (int i = 0; i < 16; i++)
      xfer(1'b1, OFS_MEM + 8'(i * 4), {24'h000000, mm[i]});
    xfer(1'b1, OFS_ACC, 32'h0000003C);
    xfer(1'b1, OFS_FLAGS, 32'h00000001);
    xfer(1'b1, OFS_IDX, 32'h00100003);
    run(32'h00000014, K_INC, 0, 2, 4, 1);
    run(32'h00000005, K_DEC, 0, 0, 4, 1);
    run(32'h00000034, K_INC, 1, 15, 10, 3);
    run(32'h00000035, K_DEC, 1, 15, 11, 3);
    run(32'h00FE34DD, K_INC, 1, 1, 23, 6);
    run(32'h000235FD, K_DEC, 1, 2, 23, 6);
    run(32'h0005BEDD, K_CMP, 1, 8, 19, 5);
    run(32'h000000A1, K_AND, 0, 1, 4, 1);
    run(32'h000000A6, K_AND, 1, 15, 7, 2);
    run(32'h000004E6, K_AND, 2, 0, 7, 2);
    run(32'h0004A6DD, K_AND, 1, 7, 19, 5);
    run(32'h000000B3, K_OR, 0, 3, 4, 1);
    run(32'h000020F6, K_OR, 2, 0, 7, 2);
    run(32'h000000B6, K_OR, 1, 15, 7, 2);
    run(32'h00F0B6FD, K_OR, 1, 0, 19, 5);
    run(32'h000000AB, K_XOR, 0, 3, 4, 1);
    run(32'h000000AF, K_XOR, 0, 7, 4, 1);
    run(32'h0000BEFD, K_CMP, 1, 0, 19, 5);
    // an opcode outside the slice starts nothing
    xfer(1'b1, OFS_CMD, 32'h000000AE);
    repeat (4) @(posedge hclk);
    rchk(OFS_STATUS, 32'h00FFFF03, {8'h00, 8'(MC_IDX_RD), 8'(ST_IDX_RD), 8'h02});
    rchk(8'h14, 32'hFFFFFFFF, 32'h00000000);
    // a register write during a run is dropped; the run still completes
    xfer(1'b1, OFS_CMD, 32'h0000003C);
    xfer(1'b1, OFS_ACC, 32'h00000055);
    rchk(OFS_STATUS, 32'h00000001, 32'h00000001);
    repeat (12) @(posedge hclk);
    rchk(OFS_ACC, 32'hFFFFFFFF, 32'h00000001);
    $display("refusal test done");
    conclude();
  end
endmodule
